// ### logic/pcdp_divider.sv
// Purpose: one integer divider with phase offset and start level
// Assumes: tick marks one rising edge of the divider input
// Notes: output selection (bypass, force) is done by the caller
`timescale 1ns/1ps
module pcdp_divider (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic tick,
	input wire logic restart,
	input wire pcdp_pkg::pcdp_div_cfg_s cfg,
	// result
	output logic div_level
);
	pcdp_pkg::pcdp_div_state_e state;
	logic [3:0] cnt;
	wire logic [3:0] limit;
	wire logic [3:0] phase_last;
	wire logic run_tick;

	assign limit = div_level ? cfg.high : cfg.low;
	assign phase_last = cfg.phase - 4'h1;
	// bypass freezes the counter: dividing logic powered down
	assign run_tick = tick & ~cfg.bypass;

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= pcdp_pkg::PCDP_ST_RUN;
			cnt <= 4'h0;
			div_level <= 1'b0;
		end else if (restart) begin
			// held here while sync stays asserted
			cnt <= 4'h0;
			div_level <= cfg.start_high;
			if (cfg.phase == 4'h0) begin
				state <= pcdp_pkg::PCDP_ST_RUN;
			end else begin
				state <= pcdp_pkg::PCDP_ST_PHASE;
			end
		end else if (run_tick) begin
			case (state)
				pcdp_pkg::PCDP_ST_PHASE: begin
					if (cnt == phase_last) begin
						state <= pcdp_pkg::PCDP_ST_RUN;
						cnt <= 4'h0;
					end else begin
						cnt <= cnt + 4'h1;
					end
				end
				pcdp_pkg::PCDP_ST_RUN: begin
					if (cnt == limit) begin
						div_level <= ~div_level;
						cnt <= 4'h0;
					end else begin
						cnt <= cnt + 4'h1;
					end
				end
				default: begin
					state <= pcdp_pkg::PCDP_ST_RUN;
					cnt <= 4'h0;
				end
			endcase
		end
	end
endmodule // pcdp_divider

// ### logic/pcdp_pkg.sv
// Purpose: shared constants and types for the channel divider pair
// Assumes: 32-bit Avalon-MM slave, byte address = 4 * register index
// Notes: register data sits in bits [7:0], upper bits read zero
package pcdp_pkg;
	// register indices
	localparam logic [9:0] IDX_DIV0_COUNTS = 10'h190;
	localparam logic [9:0] IDX_DIV0_CTRL = 10'h191;
	localparam logic [9:0] IDX_DIV0_ROUTE = 10'h192;
	localparam logic [9:0] IDX_DIV1_COUNTS = 10'h196;
	localparam logic [9:0] IDX_DIV1_CTRL = 10'h197;
	localparam logic [9:0] IDX_STATUS = 10'h19F;
	// field positions
	localparam int LOW_LSB = 4;
	localparam int HIGH_LSB = 0;
	localparam int PHASE_LSB = 0;
	localparam int BYPASS_BIT = 7;
	localparam int NOSYNC_BIT = 6;
	localparam int FORCE_BIT = 5;
	localparam int START_BIT = 4;
	localparam int DIRECT_BIT = 1;
	localparam int DUTY_BIT = 0;
	// reset values
	localparam logic [7:0] DIV0_COUNTS_RST = 8'h00;
	localparam logic [7:0] DIV0_CTRL_RST = 8'h80;
	localparam logic [7:0] DIV0_ROUTE_RST = 8'h00;
	localparam logic [7:0] DIV1_COUNTS_RST = 8'h00;
	localparam logic [7:0] DIV1_CTRL_RST = 8'h00;
	// path-select codes
	localparam logic [1:0] PATH_REF = 2'h0;
	localparam logic [1:0] PATH_VCO = 2'h2;

	typedef struct packed {
		logic [3:0] low;
		logic [3:0] high;
		logic [3:0] phase;
		logic start_high;
		logic bypass;
		logic nosync;
		logic force_high;
	} pcdp_div_cfg_s;

	typedef enum logic [0:0] {
		PCDP_ST_PHASE = 1'b0,
		PCDP_ST_RUN = 1'b1
	} pcdp_div_state_e;
endpackage

// ### logic/pcdp_sync2.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are slow levels relative to the clock
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module pcdp_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // pcdp_sync2

// ### logic/pcdp_top.sv
// Purpose: two LVPECL-style channel dividers behind an Avalon-MM slave
// Assumes: clock sources arrive as slow pin levels, sampled on CLK_SYS
// Notes: one wait state on every access; unmapped reads return zero
`timescale 1ns/1ps
module pcdp_top (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// avalon-mm slave
	input wire logic [11:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// clock source levels and chip sync (pins)
	input wire logic DIST_CLK_LVL,
	input wire logic VCO_CLK_LVL,
	input wire logic REF_CLK_LVL,
	input wire logic SYNC_N,
	// path select from the neighbouring clock-path logic
	input wire logic [1:0] PATH_SELECT,
	// first output pair
	output logic FIRST_PAIR_OUT_A,
	output logic FIRST_PAIR_OUT_B,
	// second output pair
	output logic SECOND_PAIR_OUT_A,
	output logic SECOND_PAIR_OUT_B,
	// status
	output logic DIV0_ACTIVE,
	output logic DIV1_ACTIVE,
	output logic DUTY_FIX_ON
);
	// register storage
	logic [7:0] div0_low_high_counts;
	logic [7:0] div0_control_phase;
	logic [7:0] div0_route_duty;
	logic [7:0] div1_low_high_counts;
	logic [7:0] div1_control_phase;

	// bus handshake
	logic ack;
	wire logic req;
	wire logic [9:0] idx;
	wire logic lane0_wr;
	wire logic hit_div0_counts;
	wire logic hit_div0_ctrl;
	wire logic hit_div0_route;
	wire logic hit_div1_counts;
	wire logic hit_div1_ctrl;
	wire logic hit_status;
	wire logic [7:0] rd_byte;
	wire logic [7:0] status_byte;
	wire logic [7:0] wr_byte;

	// synchronised pins
	wire logic [3:0] pin_raw;
	wire logic [3:0] pin_q;
	wire logic dist_q;
	wire logic vco_q;
	wire logic ref_q;
	wire logic sync_active;
	logic dist_prev;
	wire logic dist_tick;

	// divider configuration and results
	pcdp_pkg::pcdp_div_cfg_s cfg0;
	pcdp_pkg::pcdp_div_cfg_s cfg1;
	wire logic restart0;
	wire logic restart1;
	wire logic lvl0;
	wire logic lvl1;
	wire logic div0_sel;
	wire logic div1_sel;
	wire logic direct_on;
	wire logic route_vco;
	wire logic route_ref;
	wire logic next_first_pair;
	wire logic next_second_pair;

	// avalon decode
	assign req = AVS_READ | AVS_WRITE;
	assign idx = AVS_ADDRESS[11:2];
	assign lane0_wr = AVS_WRITE & ack & AVS_BYTEENABLE[0];
	assign wr_byte = AVS_WRITEDATA[7:0];
	assign hit_div0_counts = (idx == pcdp_pkg::IDX_DIV0_COUNTS);
	assign hit_div0_ctrl = (idx == pcdp_pkg::IDX_DIV0_CTRL);
	assign hit_div0_route = (idx == pcdp_pkg::IDX_DIV0_ROUTE);
	assign hit_div1_counts = (idx == pcdp_pkg::IDX_DIV1_COUNTS);
	assign hit_div1_ctrl = (idx == pcdp_pkg::IDX_DIV1_CTRL);
	assign hit_status = (idx == pcdp_pkg::IDX_STATUS);

	// live state for software: levels, activity, sync
	assign status_byte = {
		2'h0,
		sync_active,
		route_vco | route_ref,
		div1_sel,
		div0_sel,
		lvl1,
		lvl0
	};

	// unmapped indices read zero
	assign rd_byte =
		hit_div0_counts ? div0_low_high_counts :
		hit_div0_ctrl ? div0_control_phase :
		hit_div0_route ? div0_route_duty :
		hit_div1_counts ? div1_low_high_counts :
		hit_div1_ctrl ? div1_control_phase :
		hit_status ? status_byte :
		8'h00;

	// one wait state: ack rises the cycle after the request appears
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			ack <= 1'b0;
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			ack <= req & ~ack;
			AVS_WAITREQUEST <= ~(req & ~ack);
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (AVS_READ & ~ack) begin
			AVS_READDATA <= {24'h00_0000, rd_byte};
		end
	end

	// register writes land at the edge where waitrequest is seen low
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			div0_low_high_counts <= pcdp_pkg::DIV0_COUNTS_RST;
			div0_control_phase <= pcdp_pkg::DIV0_CTRL_RST;
			div0_route_duty <= pcdp_pkg::DIV0_ROUTE_RST;
		end else if (lane0_wr) begin
			if (hit_div0_counts) begin
				div0_low_high_counts <= wr_byte;
			end
			if (hit_div0_ctrl) begin
				div0_control_phase <= wr_byte;
			end
			if (hit_div0_route) begin
				// only the route and duty bits exist here
				div0_route_duty <= {
					6'h00,
					wr_byte[pcdp_pkg::DIRECT_BIT],
					wr_byte[pcdp_pkg::DUTY_BIT]
				};
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			div1_low_high_counts <= pcdp_pkg::DIV1_COUNTS_RST;
			div1_control_phase <= pcdp_pkg::DIV1_CTRL_RST;
		end else if (lane0_wr) begin
			if (hit_div1_counts) begin
				div1_low_high_counts <= wr_byte;
			end
			if (hit_div1_ctrl) begin
				div1_control_phase <= wr_byte;
			end
		end
	end

	// pin synchronisers
	assign pin_raw = {~SYNC_N, REF_CLK_LVL, VCO_CLK_LVL, DIST_CLK_LVL};

	pcdp_sync2 #(
		.W(4)
	) u_pin_sync (
		.clk(CLK_SYS),
		.rst(RST),
		.d(pin_raw),
		.q(pin_q)
	);

	assign dist_q = pin_q[0];
	assign vco_q = pin_q[1];
	assign ref_q = pin_q[2];
	assign sync_active = pin_q[3];

	// divider input edge, taken after the second flop
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			dist_prev <= 1'b0;
		end else begin
			dist_prev <= dist_q;
		end
	end

	assign dist_tick = dist_q & ~dist_prev;

	// configuration fields
	always_comb begin
		cfg0.low = div0_low_high_counts[pcdp_pkg::LOW_LSB +: 4];
		cfg0.high = div0_low_high_counts[pcdp_pkg::HIGH_LSB +: 4];
		cfg0.phase = div0_control_phase[pcdp_pkg::PHASE_LSB +: 4];
		cfg0.start_high = div0_control_phase[pcdp_pkg::START_BIT];
		cfg0.bypass = div0_control_phase[pcdp_pkg::BYPASS_BIT];
		cfg0.nosync = div0_control_phase[pcdp_pkg::NOSYNC_BIT];
		cfg0.force_high = div0_control_phase[pcdp_pkg::FORCE_BIT];
	end

	always_comb begin
		cfg1.low = div1_low_high_counts[pcdp_pkg::LOW_LSB +: 4];
		cfg1.high = div1_low_high_counts[pcdp_pkg::HIGH_LSB +: 4];
		cfg1.phase = div1_control_phase[pcdp_pkg::PHASE_LSB +: 4];
		cfg1.start_high = div1_control_phase[pcdp_pkg::START_BIT];
		cfg1.bypass = div1_control_phase[pcdp_pkg::BYPASS_BIT];
		cfg1.nosync = div1_control_phase[pcdp_pkg::NOSYNC_BIT];
		cfg1.force_high = div1_control_phase[pcdp_pkg::FORCE_BIT];
	end

	// sync held asserted keeps the divider parked at its start level
	assign restart0 = sync_active & ~cfg0.nosync;
	assign restart1 = sync_active & ~cfg1.nosync;

	pcdp_divider u_div0 (
		.clk(CLK_SYS),
		.rst(RST),
		.tick(dist_tick),
		.restart(restart0),
		.cfg(cfg0),
		.div_level(lvl0)
	);

	pcdp_divider u_div1 (
		.clk(CLK_SYS),
		.rst(RST),
		.tick(dist_tick),
		.restart(restart1),
		.cfg(cfg1),
		.div_level(lvl1)
	);

	// bypass wins, then the forced level, then the counted output
	assign div0_sel = cfg0.bypass ? dist_q :
		cfg0.nosync ? cfg0.force_high :
		lvl0;
	assign div1_sel = cfg1.bypass ? dist_q :
		cfg1.nosync ? cfg1.force_high :
		lvl1;

	// direct route; code 01 (and unused 11) keep the divider path
	assign direct_on = div0_route_duty[pcdp_pkg::DIRECT_BIT];
	assign route_vco = direct_on & (PATH_SELECT == pcdp_pkg::PATH_VCO);
	assign route_ref = direct_on & (PATH_SELECT == pcdp_pkg::PATH_REF);

	assign next_first_pair = route_vco ? vco_q :
		route_ref ? ref_q :
		div0_sel;
	assign next_second_pair = div1_sel;

	// all outputs registered; pins see one cycle of latency
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			FIRST_PAIR_OUT_A <= 1'b0;
			FIRST_PAIR_OUT_B <= 1'b0;
			SECOND_PAIR_OUT_A <= 1'b0;
			SECOND_PAIR_OUT_B <= 1'b0;
		end else begin
			FIRST_PAIR_OUT_A <= next_first_pair;
			FIRST_PAIR_OUT_B <= next_first_pair;
			SECOND_PAIR_OUT_A <= next_second_pair;
			SECOND_PAIR_OUT_B <= next_second_pair;
		end
	end

	// correction itself is analog; this flags it to the output stage
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			DUTY_FIX_ON <= 1'b1;
			DIV0_ACTIVE <= 1'b0;
			DIV1_ACTIVE <= 1'b0;
		end else begin
			DUTY_FIX_ON <= ~div0_route_duty[pcdp_pkg::DUTY_BIT];
			DIV0_ACTIVE <= ~cfg0.bypass;
			DIV1_ACTIVE <= ~cfg1.bypass;
		end
	end
endmodule // pcdp_top

// ### verification/pcdp_top_properties.sv
// Purpose: port-level properties of the divider pair
// Assumes: bound to pcdp_top, one wait state per access
// Notes: run lengths are judged by the bench, not here
`timescale 1ns/1ps
module pcdp_props (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// bus
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	// outputs
	input wire logic FIRST_PAIR_OUT_A,
	input wire logic FIRST_PAIR_OUT_B,
	input wire logic SECOND_PAIR_OUT_A,
	input wire logic SECOND_PAIR_OUT_B,
	input wire logic DIV0_ACTIVE,
	input wire logic DIV1_ACTIVE,
	input wire logic DUTY_FIX_ON
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);
	wire req = AVS_READ || AVS_WRITE;
	AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");
	AST_WAIT_CAUSE: assert property (!AVS_WAITREQUEST |-> $past(req))
		else $error("waitrequest low with no request");
	AST_WAIT_ANSWER: assert property (
		req && AVS_WAITREQUEST && $past(AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
		else $error("request not answered next cycle");
	AST_UPPER_ZERO: assert property (AVS_READDATA[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	AST_RST_DEFAULTS: assert property ($past(RST) && !RST |->
		!DIV0_ACTIVE && DUTY_FIX_ON && !FIRST_PAIR_OUT_A && !SECOND_PAIR_OUT_A)
		else $error("wrong levels after reset");
	AST_DIV1_DEFAULT: assert property ($past(RST) && !RST |=> DIV1_ACTIVE)
		else $error("second divider not active after reset");
	AST_FIRST_PAIR: assert property (FIRST_PAIR_OUT_A == FIRST_PAIR_OUT_B)
		else $error("first pair outputs differ");
	AST_SECOND_PAIR: assert property (SECOND_PAIR_OUT_A == SECOND_PAIR_OUT_B)
		else $error("second pair outputs differ");
	cover property (AVS_READ && !AVS_WAITREQUEST);
	cover property ($rose(DIV0_ACTIVE));
	cover property ($rose(SECOND_PAIR_OUT_A));
endmodule // pcdp_props

// ### verification/test_pecl_channel_divider_pair.sv
// Purpose: self-checking bench for the divider pair
// Assumes: source levels are slow against the system clock
// Notes: run lengths are counted in system clock cycles
`timescale 1ns/1ps
module test_pecl_channel_divider_pair;
	logic CLK_SYS = 1'b0;
	logic RST = 1'b1;
	logic [11:0] AVS_ADDRESS = 12'h000;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
	logic [3:0] AVS_BYTEENABLE = 4'h0;
	logic DIST_CLK_LVL = 1'b0;
	logic VCO_CLK_LVL = 1'b0;
	logic REF_CLK_LVL = 1'b0;
	logic SYNC_N = 1'b1;
	logic [1:0] PATH_SELECT = 2'h0;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST, FIRST_PAIR_OUT_A, FIRST_PAIR_OUT_B;
	logic SECOND_PAIR_OUT_A, SECOND_PAIR_OUT_B;
	logic DIV0_ACTIVE, DIV1_ACTIVE, DUTY_FIX_ON;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int hi, lo, d0, d3;
	logic [31:0] expq[$];
	logic [3:0] nl, nh;
	logic [7:0] rv;
	int pth[4] = '{2, 0, 1, 2};
	logic [7:0] rte[4] = '{8'h02, 8'h02, 8'h02, 8'h00};
	int ehi[4] = '{2, 8, 24, 24};

	always #20 CLK_SYS = ~CLK_SYS;

	pcdp_top u_dut (
		.CLK_SYS(CLK_SYS), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.DIST_CLK_LVL(DIST_CLK_LVL), .VCO_CLK_LVL(VCO_CLK_LVL),
		.REF_CLK_LVL(REF_CLK_LVL), .SYNC_N(SYNC_N),
		.PATH_SELECT(PATH_SELECT), .FIRST_PAIR_OUT_A(FIRST_PAIR_OUT_A),
		.FIRST_PAIR_OUT_B(FIRST_PAIR_OUT_B),
		.SECOND_PAIR_OUT_A(SECOND_PAIR_OUT_A),
		.SECOND_PAIR_OUT_B(SECOND_PAIR_OUT_B), .DIV0_ACTIVE(DIV0_ACTIVE),
		.DIV1_ACTIVE(DIV1_ACTIVE), .DUTY_FIX_ON(DUTY_FIX_ON)
	);

	task chk(input string what, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task print_verdict;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// sources run free; distinct periods tell the routes apart
	always @(posedge CLK_SYS) begin
		cyc <= cyc + 1;
		DIST_CLK_LVL <= cyc[2];
		VCO_CLK_LVL <= cyc[1];
		REF_CLK_LVL <= cyc[3];
		if (cyc > 20000) begin
			errors++;
			print_verdict;
		end
	end

	always @(posedge CLK_SYS)
		if (AVS_READ && AVS_WAITREQUEST === 1'b0)
			chk("rdata", AVS_READDATA, expq.pop_front());

	task bus(input logic w, input logic [9:0] a, input logic [7:0] d,
		input logic [3:0] be);
		AVS_ADDRESS <= {a, 2'b00};
		AVS_WRITEDATA <= {24'h00_0000, d};
		AVS_BYTEENABLE <= be;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		@(posedge CLK_SYS);
		while (AVS_WAITREQUEST !== 1'b0)
			@(posedge CLK_SYS);
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		@(posedge CLK_SYS);
	endtask

	task wr(input logic [9:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask

	task rd(input logic [9:0] a, input logic [7:0] e);
		expq.push_back({24'h00_0000, e});
		bus(1'b0, a, 8'h00, 4'h0);
	endtask

	function automatic logic pin(input bit s);
		return s ? SECOND_PAIR_OUT_A : FIRST_PAIR_OUT_A;
	endfunction

	task run(input bit s, input logic v, output int n);
		n = 0;
		while (pin(s) === v && n < 400) begin
			@(posedge CLK_SYS);
			n++;
		end
	endtask

	// first runs skipped: the counter may still hold an old setting
	task meas(input bit s, output int h, output int l);
		repeat (3) begin
			run(s, 1'b1, h);
			run(s, 1'b0, l);
		end
	endtask

	task sync_delay(input logic [3:0] p, output int d);
		wr(10'h197, {4'h1, p});
		while (cyc[2:0] != 3'd1)
			@(posedge CLK_SYS);
		SYNC_N <= 1'b0;
		repeat (24) @(posedge CLK_SYS);
		chk("parked", SECOND_PAIR_OUT_A, 1'b1);
		while (cyc[2:0] != 3'd1)
			@(posedge CLK_SYS);
		SYNC_N <= 1'b1;
		run(1'b1, 1'b1, d);
	endtask

	initial begin
		rv = 8'($urandom(40908));
		repeat (6) @(posedge CLK_SYS);
		RST <= 1'b0;
		@(posedge CLK_SYS);
		rd(10'h190, 8'h00);
		rd(10'h191, 8'h80);
		rd(10'h192, 8'h00);
		rd(10'h196, 8'h00);
		rd(10'h197, 8'h00);
		rd(10'h1A0, 8'h00);
		meas(1'b0, hi, lo);
		chk("bypass high", hi, 32'd4);
		chk("bypass low", lo, 32'd4);
		rv = 8'($urandom);
		wr(10'h196, rv);
		bus(1'b1, 10'h196, ~rv, 4'h0);
		rd(10'h196, rv);
		rv = 8'($urandom);
		wr(10'h192, rv);
		rd(10'h192, rv & 8'h03);
		// one-bit expectation: a bare ~ would widen to 32 ones
		chk("duty", DUTY_FIX_ON, rv[0] ? 32'h0000_0000 : 32'h0000_0001);
		wr(10'h192, 8'h00);
		wr(10'h191, 8'h00);
		repeat (2) @(posedge CLK_SYS);
		chk("div0 active", DIV0_ACTIVE, 1'b1);
		for (int s = 0; s < 2; s++) begin
			nl = 4'($urandom % 4);
			nh = 4'($urandom % 4);
			wr(s ? 10'h196 : 10'h190, {nl, nh});
			meas(s[0], hi, lo);
			chk("high run", hi, (nh + 1) * 8);
			chk("low run", lo, (nl + 1) * 8);
		end
		wr(10'h190, 8'h22);
		for (int i = 0; i < 4; i++) begin
			PATH_SELECT <= pth[i][1:0];
			wr(10'h192, rte[i]);
			meas(1'b0, hi, lo);
			chk("route high", hi, ehi[i]);
		end
		wr(10'h197, 8'h60);
		repeat (40) @(posedge CLK_SYS);
		chk("force high", SECOND_PAIR_OUT_A, 1'b1);
		wr(10'h197, 8'h40);
		repeat (40) @(posedge CLK_SYS);
		chk("force low", SECOND_PAIR_OUT_A, 1'b0);
		wr(10'h197, 8'h80);
		meas(1'b1, hi, lo);
		chk("bypass1 high", hi, 32'd4);
		chk("div1 active", DIV1_ACTIVE, 1'b0);
		wr(10'h196, 8'h00);
		sync_delay(4'h0, d0);
		sync_delay(4'h3, d3);
		chk("phase delay", d3 - d0, 32'd24);
		print_verdict;
	end
endmodule // test_pecl_channel_divider_pair

bind pcdp_top pcdp_props u_props (
	.CLK_SYS(CLK_SYS), .RST(RST), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST),
	.FIRST_PAIR_OUT_A(FIRST_PAIR_OUT_A), .FIRST_PAIR_OUT_B(FIRST_PAIR_OUT_B),
	.SECOND_PAIR_OUT_A(SECOND_PAIR_OUT_A),
	.SECOND_PAIR_OUT_B(SECOND_PAIR_OUT_B), .DIV0_ACTIVE(DIV0_ACTIVE),
	.DIV1_ACTIVE(DIV1_ACTIVE), .DUTY_FIX_ON(DUTY_FIX_ON)
);
